// File: core/rsc_pkg.sv
// package: register map, cause flag layout and timing constants of the reset source controller
// Notes on behaviour
// - monitor enable bit 7 switches monitor
// - supply reset needs enable and selection
// - bit 6 shows live supply level
// - monitor bits 5:0 unused, writes ignored
// - low external pin puts device in reset
// - pin reset sets flag bit 0
// - stalled system clock causes reset
// - bit 2 enables detector, reads cause
// - internal resets never drive reset pin
// - bit 5 arms comparator, low output resets
// - comparator flag bit 5 only after comparator
// - watchdog on, system clock over 12
// - watchdog overflow resets, sets its flag
// - code access above limit resets device
// - memory error reset sets bit 6
// - writing bit 4 forces reset, flags it
// - usb select arms bus reset source
// - matching supply detect edge also resets
// - usb caused reset sets usb flag
// - power-on flag bit 1, clears otherwise
// - monitor enable set by power-on or bit 7 write
// - watchdog flag bit 3 after overflow
package rsc_pkg;
	localparam int unsigned ADDR_W   = 12;
	localparam int unsigned DATA_W   = 32;
	// printed offsets are indices; the bus sees four times them
	localparam logic [11:0] IDX_SMC  = 12'h0ff;
	localparam logic [11:0] IDX_RSR  = 12'h0ef;
	localparam logic [11:0] IDX_AUX  = 12'h010;
	localparam logic [11:0] ADR_SMC  = IDX_SMC << 2;
	localparam logic [11:0] ADR_RSR  = IDX_RSR << 2;
	localparam logic [11:0] ADR_AUX  = IDX_AUX << 2;
	// monitor control fields
	localparam int unsigned SMC_EN   = 7;
	localparam int unsigned SMC_STAT = 6;
	// reset source register fields
	localparam int unsigned RSR_POR  = 1;
	localparam int unsigned RSR_MCD  = 2;
	localparam int unsigned RSR_SW   = 4;
	localparam int unsigned RSR_CMP  = 5;
	localparam int unsigned RSR_USB  = 7;
	// auxiliary control fields
	localparam int unsigned AUX_POL  = 0;
	localparam int unsigned AUX_WOFF = 1;
	localparam logic        MON_RST  = 1'b1;
	localparam logic [3:0]  WDT_DIV  = 4'hc;
	localparam logic [3:0]  HOLD_CYC = 4'h4;
	localparam int unsigned CLK_HZ   = 50_000_000;
	localparam logic [31:0] ZERO32   = 32'h0000_0000;
	// cause flags, packed in register bit order 7..0
	typedef struct packed {
		logic usb;
		logic mem;
		logic cmp;
		logic sw;
		logic wdt;
		logic missing_clock_detector;
		logic por;
		logic pin;
	} rsc_flags_t;
	// pins sampled from outside the clock domain
	typedef struct packed {
		logic ext_n;
		logic sup_ok;
		logic cmp_out;
		logic vbus;
		logic clk_mon;
	} rsc_pins_t;
	typedef enum logic [0:0] {
		ST_RUN  = 1'b0,
		ST_HOLD = 1'b1
	} rsc_state_t;
endpackage

// File: core/rsc_top.sv
// reset source controller: merges reset requests, records causes, avalon register slave
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module rsc_top #(
	parameter int unsigned        CODE_AW    = 16,
	parameter logic [15:0]        CODE_LIMIT = 16'h7fff,
	parameter int unsigned        MCD_W      = 8,
	parameter logic [MCD_W-1:0]   MCD_TO     = 8'h64
) (
	input  wire logic                       core_clk,
	input  wire logic                       reset,
	input  wire logic [rsc_pkg::ADDR_W-1:0] avs_address,
	input  wire logic                       avs_read,
	input  wire logic                       avs_write,
	input  wire logic [rsc_pkg::DATA_W-1:0] avs_writedata,
	output var  logic [rsc_pkg::DATA_W-1:0] avs_readdata,
	output var  logic                       avs_waitrequest,
	input  wire logic                       ext_reset_pin_n_in,
	output var  logic                       ext_reset_pin_out,
	output var  logic                       ext_reset_pin_oe,
	input  wire logic                       supply_above_in,
	input  wire logic                       comparator_out_in,
	input  wire logic                       vbus_sense_in,
	input  wire logic                       system_clock_mon_in,
	input  wire logic                       wdt_overflow,
	input  wire logic                       usb_enabled,
	input  wire logic                       usb_bus_reset,
	input  wire logic                       prog_valid,
	input  wire logic [CODE_AW-1:0]         prog_addr,
	input  wire logic                       table_valid,
	input  wire logic [CODE_AW-1:0]         table_addr,
	input  wire logic                       fetch_valid,
	input  wire logic [CODE_AW-1:0]         fetch_addr,
	output var  logic                       sys_reset,
	output var  logic                       supply_monitor_on,
	output var  logic                       wdt_enable,
	output var  logic                       wdt_tick
);
	rsc_pkg::rsc_pins_t  s1_r, s2_r;
	rsc_pkg::rsc_flags_t req, cause_r, flags_r;
	rsc_pkg::rsc_state_t st_r;
	logic                waitreq_r, sys_reset_r, pin_oe_r, pin_out_r;
	logic [31:0]         rdata_r;
	logic                mon_en_r, sup_sel_r, mcd_en_r, cmp_en_r, usb_sel_r;
	logic                pol_r, wdt_en_r, wdt_tick_r, vbus_d_r, clkmon_d_r;
	logic [3:0]          wdt_div_r, hold_r;
	logic [MCD_W-1:0]    mcd_cnt_r;
	logic                wr_acc, hold_lvl, vbus_edge, any_req, pin_low;
	logic [1:0]          oe_hist_r;

	// true when an access lands above user code space
	function automatic logic over_limit(input logic v, input logic [CODE_AW-1:0] a);
		over_limit = v && (a > CODE_LIMIT);
	endfunction

	// one cause per reset; supply loss outranks the pin, edge events rank last
	function automatic rsc_pkg::rsc_flags_t pick(input rsc_pkg::rsc_flags_t q);
		rsc_pkg::rsc_flags_t c;
		c = '0;
		if (q.por)
			c.por = 1'b1;
		else if (q.pin)
			c.pin = 1'b1;
		else if (q.missing_clock_detector)
			c.missing_clock_detector = 1'b1;
		else if (q.cmp)
			c.cmp = 1'b1;
		else if (q.wdt)
			c.wdt = 1'b1;
		else if (q.mem)
			c.mem = 1'b1;
		else if (q.sw)
			c.sw = 1'b1;
		else
			c.usb = q.usb;
		return c;
	endfunction

	function automatic logic [7:0] reg_read(input logic [11:0] a);
		logic [7:0] d;
		d = '0;
		case (a)
			rsc_pkg::ADR_SMC:
			begin
				d[rsc_pkg::SMC_EN]   = mon_en_r;
				d[rsc_pkg::SMC_STAT] = s2_r.sup_ok; // live level
			end
			rsc_pkg::ADR_RSR:
				d = flags_r;                        // reads show causes
			rsc_pkg::ADR_AUX:
			begin
				d[rsc_pkg::AUX_POL]  = pol_r;
				d[rsc_pkg::AUX_WOFF] = !wdt_en_r;
			end
			default:
				d = '0;
		endcase
		return d;
	endfunction

	// two-stage synchroniser for every pin; only stage two is read
	always_ff @(posedge core_clk)
	begin
		s1_r <= {ext_reset_pin_n_in, supply_above_in, comparator_out_in, vbus_sense_in, system_clock_mon_in};
		s2_r <= s1_r;
		vbus_d_r   <= s2_r.vbus;
		clkmon_d_r <= s2_r.clk_mon;
	end

	// bus: answer one cycle after the request is seen, write lands when waitrequest is low
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			waitreq_r <= 1'b1;
			rdata_r   <= rsc_pkg::ZERO32;
		end
		else if (waitreq_r && (avs_read || avs_write))
		begin
			waitreq_r <= 1'b0;
			rdata_r   <= {24'h00_0000, reg_read(avs_address)};
		end
		else
			waitreq_r <= 1'b1;
	end

	// writes during a held reset are dropped so the enables stay cleared
	assign wr_acc    = avs_write && !waitreq_r && !sys_reset_r;
	assign vbus_edge = pol_r ? (s2_r.vbus && !vbus_d_r) : (!s2_r.vbus && vbus_d_r);

	// reset requests in flag layout
	always_comb
	begin
		req     = '0;
		req.por = mon_en_r && sup_sel_r && !s2_r.sup_ok;
		req.pin = pin_low;
		req.missing_clock_detector = mcd_en_r && (mcd_cnt_r == MCD_TO);
		req.cmp = cmp_en_r && !s2_r.cmp_out;
		req.wdt = wdt_en_r && wdt_overflow;
		req.mem = over_limit(prog_valid, prog_addr) || over_limit(table_valid, table_addr)
			|| over_limit(fetch_valid, fetch_addr);
		req.sw  = wr_acc && (avs_address == rsc_pkg::ADR_RSR) && avs_writedata[rsc_pkg::RSR_SW];
		req.usb = usb_sel_r && ((usb_enabled && usb_bus_reset) || vbus_edge);
	end
	assign any_req = |req;

	// drive history of the pin: the synced pin echoes our own pull for two edges after release
	always_ff @(posedge core_clk)
	begin
		if (reset)
			oe_hist_r <= 2'h3;
		else
			oe_hist_r <= {oe_hist_r[0], pin_oe_r};
	end

	// pin request ignored while we pull it ourselves, else a supply reset would hold itself
	// forever and chain into a false pin reset; an outside pull during it is lost
	assign pin_low = !s2_r.ext_n && !pin_oe_r && (oe_hist_r == 2'h0);

	// level causes keep the device held beyond the minimum width
	assign hold_lvl = pin_low || (cause_r.por && mon_en_r && !s2_r.sup_ok)
		|| (cause_r.cmp && !s2_r.cmp_out);

	// sequencer: enter on any request, leave after the hold and once levels clear
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			st_r        <= rsc_pkg::ST_HOLD;
			sys_reset_r <= 1'b1;
			cause_r     <= '{por: 1'b1, default: 1'b0};
			hold_r      <= rsc_pkg::HOLD_CYC;
			pin_oe_r    <= 1'b1;
			flags_r     <= '0;
		end
		else
		begin
			case (st_r)
				rsc_pkg::ST_RUN:
				if (any_req)
				begin
					st_r        <= rsc_pkg::ST_HOLD;
					sys_reset_r <= 1'b1;
					cause_r     <= pick(req);
					hold_r      <= rsc_pkg::HOLD_CYC;
					pin_oe_r    <= req.por;                 // only supply loss drives the pin
				end
				rsc_pkg::ST_HOLD:
				if (hold_r != 4'h0)
					hold_r <= hold_r - 4'h1;
				else if (!hold_lvl)
				begin
					st_r        <= rsc_pkg::ST_RUN;
					sys_reset_r <= 1'b0;
					pin_oe_r    <= 1'b0;
					flags_r     <= cause_r;
				end
				default:
					st_r <= rsc_pkg::ST_RUN;
			endcase
		end
	end

	// monitor enable: power-on or a bit 7 write sets it, other resets leave it
	always_ff @(posedge core_clk)
	begin
		if (reset)
			mon_en_r <= rsc_pkg::MON_RST;
		else if (wr_acc && avs_address == rsc_pkg::ADR_SMC)
			mon_en_r <= avs_writedata[rsc_pkg::SMC_EN]; // bits 5:0 dropped
	end

	// source enables: cleared by every reset, set by register writes
	always_ff @(posedge core_clk)
	begin
		if (reset || sys_reset_r)
		begin
			sup_sel_r <= 1'b0;
			mcd_en_r  <= 1'b0;
			cmp_en_r  <= 1'b0;
			usb_sel_r <= 1'b0;
			pol_r     <= 1'b0;
		end
		else if (wr_acc && avs_address == rsc_pkg::ADR_RSR)
		begin
			sup_sel_r <= avs_writedata[rsc_pkg::RSR_POR];
			mcd_en_r  <= avs_writedata[rsc_pkg::RSR_MCD];
			cmp_en_r  <= avs_writedata[rsc_pkg::RSR_CMP];
			usb_sel_r <= avs_writedata[rsc_pkg::RSR_USB];
		end
		else if (wr_acc && avs_address == rsc_pkg::ADR_AUX)
			pol_r <= avs_writedata[rsc_pkg::AUX_POL];
	end

	// watchdog: on after any reset, tick every twelfth clock
	always_ff @(posedge core_clk)
	begin
		if (reset || sys_reset_r)
		begin
			wdt_en_r   <= 1'b1;
			wdt_div_r  <= 4'h0;
			wdt_tick_r <= 1'b0;
		end
		else
		begin
			if (wr_acc && avs_address == rsc_pkg::ADR_AUX)
				wdt_en_r <= !avs_writedata[rsc_pkg::AUX_WOFF];
			wdt_tick_r <= wdt_en_r && (wdt_div_r == rsc_pkg::WDT_DIV - 4'h1);
			if (!wdt_en_r || wdt_div_r == rsc_pkg::WDT_DIV - 4'h1)
				wdt_div_r <= 4'h0;
			else
				wdt_div_r <= wdt_div_r + 4'h1;
		end
	end

	// clock-loss timer: core_clk is the free reference, the watched clock retriggers it
	always_ff @(posedge core_clk)
	begin
		if (reset || !mcd_en_r || (s2_r.clk_mon != clkmon_d_r))
			mcd_cnt_r <= '0;
		else if (mcd_cnt_r != MCD_TO)
			mcd_cnt_r <= mcd_cnt_r + 1'b1;
	end

	// pin is open drain: it only ever pulls low
	always_ff @(posedge core_clk)
		pin_out_r <= 1'b0;

	assign avs_readdata      = rdata_r;
	assign avs_waitrequest   = waitreq_r;
	assign ext_reset_pin_out = pin_out_r;
	assign ext_reset_pin_oe  = pin_oe_r;
	assign sys_reset         = sys_reset_r;
	assign supply_monitor_on = mon_en_r;
	assign wdt_enable        = wdt_en_r;
	assign wdt_tick          = wdt_tick_r;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	sequence s_enter;
		!sys_reset_r ##1 sys_reset_r;
	endsequence
	sequence s_sw_write;
		wr_acc && avs_address == rsc_pkg::ADR_RSR && avs_writedata[rsc_pkg::RSR_SW];
	endsequence

	a_supply_gate: assert property (s_enter ##0 cause_r.por |-> $past(mon_en_r && sup_sel_r))
		else $error("supply reset without enable and selection");
	a_pin_internal: assert property (sys_reset_r && !cause_r.por |-> !pin_oe_r)
		else $error("internal reset drove the pin");
	a_flags_onehot: assert property ($fell(sys_reset_r) |-> flags_r == $past(cause_r) && $onehot(flags_r))
		else $error("flags not the single cause");
	a_sw_force: assert property (s_sw_write |=> sys_reset_r ##1 sys_reset_r)
		else $error("software force did not reset");
	a_mcd_fire: assert property (req.missing_clock_detector && !req.por && !req.pin && !sys_reset_r |=> sys_reset_r && cause_r.missing_clock_detector)
		else $error("clock loss did not reset");
	a_cmp_reset: assert property (cmp_en_r && !s2_r.cmp_out && !sys_reset_r |=> sys_reset_r)
		else $error("comparator low did not reset");
	a_mem_error: assert property (req.mem && !sys_reset_r |=> sys_reset_r)
		else $error("code access error did not reset");
	a_usb_select: assert property (s_enter ##0 cause_r.usb |-> $past(usb_sel_r))
		else $error("usb reset while not selected");
	a_mon_keep: assert property (sys_reset_r |=> mon_en_r == $past(mon_en_r))
		else $error("monitor enable changed by reset");
	a_wdt_exit: assert property ($fell(sys_reset_r) |-> wdt_en_r ##1 wdt_en_r)
		else $error("watchdog not on after reset");
	a_wdt_spacing: assert property (wdt_tick_r |=> !wdt_tick_r [*8])
		else $error("watchdog ticks too close");
	a_rsvd_zero: assert property (!waitreq_r && avs_address == rsc_pkg::ADR_SMC |-> avs_readdata[5:0] == 6'h00)
		else $error("unused monitor bits not zero");
	a_hold_min: assert property (s_enter |-> sys_reset_r [*5])
		else $error("reset shorter than hold");
	a_bus_answer: assert property ((avs_read || avs_write) && waitreq_r |-> ##[0:1] !waitreq_r)
		else $error("bus request not answered");
endmodule
`default_nettype wire

// File: tb/rsc_src_model.sv
// source model: reset pin wire with pull-up and the watched system clock
`timescale 1ns/1ps
`default_nettype none
module rsc_src_model (
	input  wire logic core_clk,
	input  wire logic pull_low,
	input  wire logic stall,
	input  wire logic dut_oe,
	input  wire logic dut_out,
	output var  logic pin_n,
	output var  logic clk_mon
);
	logic tog_r = 1'b0;

	// open-drain wire: any enabled driver pulls it low, the pull-up wins otherwise
	always_comb pin_n = (pull_low || (dut_oe && !dut_out)) ? 1'b0 : 1'b1;
	// watched clock toggles on every rising core_clk edge; stall freezes its level to model a lost clock
	always @(posedge core_clk)
		if (!stall)
			tog_r <= !tog_r;
	assign clk_mon = tog_r;
endmodule
`default_nettype wire

// File: tb/reset_source_controller_test.sv
// testbench: register accesses and every reset source, checking cause flags
`timescale 1ns/1ps
`default_nettype none
module reset_source_controller_test;
	logic        core_clk      = 1'b0;
	logic        reset         = 1'b1;
	logic [11:0] avs_address   = 12'h000;
	logic        avs_read      = 1'b0;
	logic        avs_write     = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        pin_n, pin_out, pin_oe, clk_mon, sys_reset, mon_on, wdt_enable, wdt_tick;
	logic        pull_low = 1'b0, stall = 1'b0, sup = 1'b1, cmp = 1'b1, vbus = 1'b0, wdt_ovf = 1'b0;
	logic        usb_en = 1'b0, usb_rst = 1'b0, pv = 1'b0, tv = 1'b0, fv = 1'b0;
	logic [15:0] pa = 16'h0000, ta = 16'h0000, fa = 16'h0000;
	logic [31:0] q;
	int          num_errors = 0;
	int          tests_run  = 0;
	int          k, n;

	// half period of 10 ns gives 50 MHz
	always #10 core_clk = !core_clk;

	rsc_src_model src (.core_clk(core_clk), .pull_low(pull_low), .stall(stall), .dut_oe(pin_oe),
		.dut_out(pin_out), .pin_n(pin_n), .clk_mon(clk_mon));

	rsc_top dut (.core_clk(core_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .ext_reset_pin_n_in(pin_n), .ext_reset_pin_out(pin_out),
		.ext_reset_pin_oe(pin_oe), .supply_above_in(sup), .comparator_out_in(cmp), .vbus_sense_in(vbus),
		.system_clock_mon_in(clk_mon), .wdt_overflow(wdt_ovf), .usb_enabled(usb_en), .usb_bus_reset(usb_rst),
		.prog_valid(pv), .prog_addr(pa), .table_valid(tv), .table_addr(ta), .fetch_valid(fv),
		.fetch_addr(fa), .sys_reset(sys_reset), .supply_monitor_on(mon_on), .wdt_enable(wdt_enable),
		.wdt_tick(wdt_tick));

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one avalon access; request held until waitrequest is sampled low
	task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr;
		avs_read      <= !wr;
		do
			@(posedge core_clk);
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask

	// waits for a reset to come and go, then checks pin drive and the cause flags
	task expect_reset(input logic [7:0] flags, input logic oe);
		logic seen_oe;
		seen_oe = 1'b0;
		n = 0;
		while (sys_reset !== 1'b1 && n < 400)
		begin
			@(posedge core_clk);
			n++;
		end
		while (sys_reset !== 1'b0 && n < 800)
		begin
			@(posedge core_clk);
			seen_oe = seen_oe | pin_oe;
			n++;
		end
		chk({31'h0, sys_reset}, 32'h0);
		chk({31'h0, seen_oe}, {31'h0, oe});
		chk({31'h0, pin_out}, 32'h0);
		bus(1'b0, rsc_pkg::ADR_RSR, 32'h0);
		chk(q, {24'h0, flags});
	endtask

	// no reset may start during the given number of cycles
	task quiet(input int cyc);
		logic hit;
		hit = 1'b0;
		repeat (cyc)
		begin
			@(posedge core_clk);
			hit = hit | sys_reset;
		end
		chk({31'h0, hit}, 32'h0);
	endtask

	// one-cycle code memory access of kind j: programming, table read, fetch
	task code_access(input int j, input logic [15:0] a);
		@(posedge core_clk);
		pa <= a;
		ta <= a;
		fa <= a;
		pv <= (j == 0);
		tv <= (j == 1);
		fv <= (j == 2);
		@(posedge core_clk);
		{pv, tv, fv} <= 3'h0;
	endtask

	task end_of_test;
		$display("errors %0d comparisons %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// hang guard: the sequence needs well under 10000 cycles
	initial
	begin
		#1000000;
		num_errors++;
		end_of_test();
	end

	initial
	begin
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		expect_reset(8'h02, 1'b1);
		bus(1'b0, rsc_pkg::ADR_SMC, 32'h0);
		chk(q & 32'hc0, 32'hc0);
		bus(1'b0, 12'h100, 32'h0);
		chk(q, 32'h0);
		// a write with only the unused bits high switches the monitor off
		bus(1'b1, rsc_pkg::ADR_SMC, 32'h3f);
		bus(1'b0, rsc_pkg::ADR_SMC, 32'h0);
		chk({31'h0, q[7]}, 32'h0);
		chk({31'h0, mon_on}, 32'h0);
		bus(1'b1, rsc_pkg::ADR_AUX, 32'h02);
		bus(1'b0, rsc_pkg::ADR_AUX, 32'h0);
		chk({31'h0, wdt_enable}, 32'h0);
		bus(1'b1, rsc_pkg::ADR_RSR, 32'h10);
		expect_reset(8'h10, 1'b0);
		chk({31'h0, wdt_enable}, 32'h1);
		bus(1'b0, rsc_pkg::ADR_SMC, 32'h0);
		chk({31'h0, q[7]}, 32'h0);
		bus(1'b1, rsc_pkg::ADR_SMC, 32'h80);
		// watchdog tick spacing in system clocks
		n = 0;
		while (wdt_tick !== 1'b1 && n < 40)
		begin
			@(posedge core_clk);
			n++;
		end
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (wdt_tick !== 1'b1 && n < 40);
		chk(n, 12);
		pull_low <= 1'b1;
		repeat (10) @(posedge core_clk);
		pull_low <= 1'b0;
		expect_reset(8'h01, 1'b0);
		stall <= 1'b1;
		quiet(150);
		stall <= 1'b0;
		bus(1'b1, rsc_pkg::ADR_RSR, 32'h04);
		stall <= 1'b1;
		expect_reset(8'h04, 1'b0);
		stall <= 1'b0;
		// comparator already high and settled before it is armed
		bus(1'b1, rsc_pkg::ADR_RSR, 32'h20);
		quiet(10);
		cmp <= 1'b0;
		repeat (6) @(posedge core_clk);
		cmp <= 1'b1;
		expect_reset(8'h20, 1'b0);
		@(posedge core_clk);
		wdt_ovf <= 1'b1;
		@(posedge core_clk);
		wdt_ovf <= 1'b0;
		expect_reset(8'h08, 1'b0);
		for (k = 0; k < 3; k++)
		begin
			code_access(k, 16'h7fff);
			quiet(5);
			code_access(k, 16'h8000);
			expect_reset(8'h40, 1'b0);
		end
		bus(1'b1, rsc_pkg::ADR_RSR, 32'h80);
		usb_rst <= 1'b1;
		quiet(10);
		usb_rst <= 1'b0;
		usb_en  <= 1'b1;
		@(posedge core_clk);
		usb_rst <= 1'b1;
		@(posedge core_clk);
		usb_rst <= 1'b0;
		expect_reset(8'h80, 1'b0);
		// both supply-detect polarities, starting from the opposite level
		for (k = 1; k >= 0; k--)
		begin
			vbus <= !k[0];
			repeat (4) @(posedge core_clk);
			bus(1'b1, rsc_pkg::ADR_AUX, {31'h0, k[0]});
			bus(1'b1, rsc_pkg::ADR_RSR, 32'h80);
			quiet(5);
			vbus <= k[0];
			expect_reset(8'h80, 1'b0);
		end
		sup <= 1'b0;
		quiet(10);
		bus(1'b0, rsc_pkg::ADR_SMC, 32'h0);
		chk({31'h0, q[6]}, 32'h0);
		bus(1'b1, rsc_pkg::ADR_SMC, 32'h00);
		bus(1'b1, rsc_pkg::ADR_RSR, 32'h02);
		quiet(10);
		sup <= 1'b1;
		// monitor enabled and settled before it is selected
		bus(1'b1, rsc_pkg::ADR_SMC, 32'h80);
		quiet(5);
		bus(1'b1, rsc_pkg::ADR_RSR, 32'h02);
		sup <= 1'b0;
		repeat (6) @(posedge core_clk);
		sup <= 1'b1;
		expect_reset(8'h02, 1'b1);
		// a second power-on in mid-run must switch a disabled monitor back on
		bus(1'b1, rsc_pkg::ADR_SMC, 32'h00);
		reset <= 1'b1;
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		expect_reset(8'h02, 1'b1);
		chk({31'h0, mon_on}, 32'h1);
		end_of_test();
	end
endmodule
`default_nettype wire
